// ---- pkg/wwdt_defines.svh ----
/*
  offsets, field positions, reset values and counts of the windowed watchdog.
  assumes a plain 8-bit register port with a 4-bit word address.
*/
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WWDT_ADDR_CTRL 4'h0
`define WWDT_ADDR_RELOAD 4'h1
`define WWDT_ADDR_WINB 4'h2
`define WWDT_ADDR_STATUS 4'h3
`define WWDT_ADDR_CNT_LO 4'h4
`define WWDT_ADDR_CNT_HI 4'h5
`define WWDT_ADDR_SERVICE 4'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WWDT_CTRL_PRESEL 0
`define WWDT_CTRL_WINEN 1
`define WWDT_CTRL_ENABLE 2
`define WWDT_STAT_NMI 0
`define WWDT_STAT_PREWARN 1
`define WWDT_STAT_RESET 2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define WWDT_CTRL_RST 3'h0
`define WWDT_RELOAD_RST 8'h00
`define WWDT_WINB_RST 8'h00
`define WWDT_DIV_FAST_LAST 7'h01
`define WWDT_DIV_SLOW_LAST 7'h7F
`define WWDT_PREWARN_LAST 6'h2F

`endif

// ---- pkg/wwdt_pkg.sv ----
/*
  types of the windowed watchdog.
  assumes wwdt_defines.svh supplies the numbers.
*/
package wwdt_pkg;

  typedef enum logic [1:0] {
    WWDT_ST_RUN     = 2'b00,
    WWDT_ST_PREWARN = 2'b01,
    WWDT_ST_RESET   = 2'b10
  } wwdt_state_t;

  typedef struct packed {
    logic enable;
    logic win_enable;
    logic presel;
  } wwdt_ctrl_t;

  typedef struct packed {
    logic reset_req;
    logic prewarn;
    logic nmi_flag;
  } wwdt_status_t;

endpackage

// ---- design/wwdt_top.sv ----
/*
  windowed watchdog: prescaler, 16-bit counter, window check, prewarning
  and system reset request, with a small register port.
  assumes one 100 MHz clock, synchronous active-high reset, and that the
  debug level and register strobes come from logic on the same clock.
*/
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "wwdt_defines.svh"

module wwdt_top
  import wwdt_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  // system side
  input wire logic debug_mode_in,
  output logic nmi_request_out,
  output logic timeout_nmi_flag_out,
  output logic system_reset_request_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic [15:0] cnt, input logic [7:0] bnd);
    in_window = (cnt < {bnd, 8'h00});
  endfunction

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wwdt_ctrl_t ctrl_ff;
  logic [7:0] reload_high_byte_ff;
  logic [7:0] window_boundary_byte_ff;
  logic [15:0] counter_ff;
  logic [6:0] presc_ff;
  logic [5:0] prewarn_cnt_ff;
  wwdt_state_t state_ff;
  logic timeout_nmi_flag_ff;
  logic nmi_pulse_ff;
  logic [7:0] rdata_ff;

  logic tick;
  logic service;
  logic hit;
  logic svc_valid;
  logic svc_invalid;
  logic overflow;
  logic [6:0] div_last;
  wwdt_status_t status;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign div_last = ctrl_ff.presel ? `WWDT_DIV_SLOW_LAST : `WWDT_DIV_FAST_LAST;
  // counting halts in debug so the debugger needs no refresh
  assign tick = ctrl_ff.enable && !debug_mode_in && (state_ff != WWDT_ST_RESET)
                && (presc_ff == div_last);
  assign service = write_in && is_addr(addr_in, `WWDT_ADDR_SERVICE);
  // a boundary above reload shortens the usable period by forbidding early services
  assign hit = ctrl_ff.win_enable && in_window(counter_ff, window_boundary_byte_ff);
  // only a service while running and enabled is judged; later ones are ignored
  assign svc_valid = service && ctrl_ff.enable && (state_ff == WWDT_ST_RUN) && !hit;
  assign svc_invalid = service && ctrl_ff.enable && (state_ff == WWDT_ST_RUN) && hit;
  // a service in the same cycle as the last tick wins over the overflow
  assign overflow = tick && (state_ff == WWDT_ST_RUN) && (counter_ff == 16'hFFFF) && !service;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_ff <= `WWDT_CTRL_RST;
    end else if (write_in && is_addr(addr_in, `WWDT_ADDR_CTRL) && state_ff == WWDT_ST_RUN) begin
      // frozen after prewarning so software cannot switch the reset off
      ctrl_ff.presel <= wdata_in[`WWDT_CTRL_PRESEL];
      ctrl_ff.win_enable <= wdata_in[`WWDT_CTRL_WINEN];
      ctrl_ff.enable <= wdata_in[`WWDT_CTRL_ENABLE];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      reload_high_byte_ff <= `WWDT_RELOAD_RST;
    end else if (write_in && is_addr(addr_in, `WWDT_ADDR_RELOAD)) begin
      reload_high_byte_ff <= wdata_in;
    end
  end

  // boundary below reload makes the window empty in practice; not policed
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      window_boundary_byte_ff <= `WWDT_WINB_RST;
    end else if (write_in && is_addr(addr_in, `WWDT_ADDR_WINB)) begin
      window_boundary_byte_ff <= wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  // prescaler restarts on service so every period starts on a full tick
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      presc_ff <= 7'h00;
    end else if (svc_valid || tick) begin
      presc_ff <= 7'h00;
    end else if (ctrl_ff.enable && !debug_mode_in && state_ff != WWDT_ST_RESET) begin
      presc_ff <= presc_ff + 7'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      counter_ff <= 16'h0000;
    end else if (svc_valid) begin
      counter_ff <= {reload_high_byte_ff, 8'h00};
    end else if (tick) begin
      counter_ff <= counter_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // prewarning and reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff <= WWDT_ST_RUN;
    end else begin
      case (state_ff)
        WWDT_ST_RUN: begin
          if (overflow || svc_invalid) begin
            state_ff <= WWDT_ST_PREWARN;
          end
        end
        WWDT_ST_PREWARN: begin
          if (tick && prewarn_cnt_ff == `WWDT_PREWARN_LAST) begin
            state_ff <= WWDT_ST_RESET;
          end
        end
        WWDT_ST_RESET: begin
          state_ff <= WWDT_ST_RESET;
        end
        default: begin
          state_ff <= WWDT_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prewarn_cnt_ff <= 6'h00;
    end else if (state_ff == WWDT_ST_PREWARN && tick) begin
      prewarn_cnt_ff <= prewarn_cnt_ff + 6'h01;
    end
  end

  // flag is write-one-to-clear; the setting event wins over a clear
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      timeout_nmi_flag_ff <= 1'b0;
    end else if (overflow) begin
      timeout_nmi_flag_ff <= 1'b1;
    end else if (write_in && is_addr(addr_in, `WWDT_ADDR_STATUS) && wdata_in[`WWDT_STAT_NMI]) begin
      timeout_nmi_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      nmi_pulse_ff <= 1'b0;
    end else begin
      nmi_pulse_ff <= overflow;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  assign status.reset_req = (state_ff == WWDT_ST_RESET);
  assign status.prewarn = (state_ff == WWDT_ST_PREWARN);
  assign status.nmi_flag = timeout_nmi_flag_ff;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_ff <= 8'h00;
    end else if (read_in) begin
      case (addr_in)
        `WWDT_ADDR_CTRL: rdata_ff <= {5'h00, ctrl_ff};
        `WWDT_ADDR_RELOAD: rdata_ff <= reload_high_byte_ff;
        `WWDT_ADDR_WINB: rdata_ff <= window_boundary_byte_ff;
        `WWDT_ADDR_STATUS: rdata_ff <= {5'h00, status};
        `WWDT_ADDR_CNT_LO: rdata_ff <= counter_ff[7:0];
        `WWDT_ADDR_CNT_HI: rdata_ff <= counter_ff[15:8];
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_out = rdata_ff;
  assign nmi_request_out = nmi_pulse_ff;
  assign timeout_nmi_flag_out = timeout_nmi_flag_ff;
  assign system_reset_request_out = (state_ff == WWDT_ST_RESET);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_valid_service;
    svc_valid;
  endsequence

  sequence s_enter_prewarn;
    (state_ff == WWDT_ST_RUN) ##1 (state_ff == WWDT_ST_PREWARN);
  endsequence

  property p_count_step;
    @(posedge clock_in) disable iff (reset_in)
    (tick && !svc_valid) |=> (counter_ff == $past(counter_ff) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed a tick");

  property p_fast_rate;
    @(posedge clock_in) disable iff (reset_in)
    (tick && !ctrl_ff.presel && !write_in && state_ff == WWDT_ST_RUN)
      ##1 (!debug_mode_in && !svc_valid && !write_in) ##1 !debug_mode_in |-> tick;
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("divide-by-2 tick spacing wrong");

  property p_service_load;
    @(posedge clock_in) disable iff (reset_in)
    s_valid_service |=> (counter_ff == {$past(reload_high_byte_ff), 8'h00});
  endproperty
  a_service_load: assert property (p_service_load) else $error("service did not reload");

  property p_resume;
    @(posedge clock_in) disable iff (reset_in)
    s_valid_service ##2 (tick && !svc_valid) |=> (counter_ff[7:0] == 8'h01);
  endproperty
  a_resume: assert property (p_resume) else $error("count did not resume from reload");

  property p_overflow_nmi;
    @(posedge clock_in) disable iff (reset_in)
    overflow |=> (timeout_nmi_flag_ff && nmi_request_out && state_ff == WWDT_ST_PREWARN) ##1 !nmi_request_out;
  endproperty
  a_overflow_nmi: assert property (p_overflow_nmi) else $error("overflow did not raise nmi");

  property p_prewarn_end;
    @(posedge clock_in) disable iff (reset_in)
    (state_ff == WWDT_ST_PREWARN && tick && prewarn_cnt_ff == `WWDT_PREWARN_LAST) |=> system_reset_request_out;
  endproperty
  a_prewarn_end: assert property (p_prewarn_end) else $error("prewarning did not end in reset");

  property p_prewarn_start;
    @(posedge clock_in) disable iff (reset_in)
    s_enter_prewarn |-> (prewarn_cnt_ff == 6'h00 && !system_reset_request_out);
  endproperty
  a_prewarn_start: assert property (p_prewarn_start) else $error("prewarning count not fresh");

  property p_invalid_service;
    @(posedge clock_in) disable iff (reset_in)
    svc_invalid |=> (state_ff == WWDT_ST_PREWARN && !nmi_request_out);
  endproperty
  a_invalid_service: assert property (p_invalid_service) else $error("window service mishandled");

  property p_window_span;
    @(posedge clock_in) disable iff (reset_in)
    (service && ctrl_ff.enable && ctrl_ff.win_enable && state_ff == WWDT_ST_RUN
      && counter_ff < {window_boundary_byte_ff, 8'h00}) |=> (state_ff != WWDT_ST_RUN);
  endproperty
  a_window_span: assert property (p_window_span) else $error("service inside window accepted");

  property p_debug_hold;
    @(posedge clock_in) disable iff (reset_in)
    (debug_mode_in && !svc_valid) |=> $stable(counter_ff);
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("counter moved in debug");

  property p_reset_sticky;
    @(posedge clock_in) disable iff (reset_in)
    system_reset_request_out |=> system_reset_request_out [*3];
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("reset request dropped");

endmodule

// ---- dv/testbench.sv ----
/*
  self-checking testbench of the windowed watchdog: register port, overflow,
  prewarning, window check, debug freeze and both prescale rates.
  assumes wwdt_top with the register map of wwdt_defines.svh and one 100 MHz clock.
*/
`timescale 1ns/100ps
`include "wwdt_defines.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock_in;
  logic reset_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic debug_mode_in = 1'b0;
  logic [7:0] rdata_out;
  logic nmi_request_out;
  logic timeout_nmi_flag_out;
  logic system_reset_request_out;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  logic [7:0] rd;

  wwdt_top u_wwdt_top (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .debug_mode_in(debug_mode_in),
    .nmi_request_out(nmi_request_out),
    .timeout_nmi_flag_out(timeout_nmi_flag_out),
    .system_reset_request_out(system_reset_request_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clock_in);
    reset_in <= 1'b1;
    debug_mode_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    reset_in <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    write_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    write_in <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    read_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // sel 0 waits for the nmi pulse, sel 1 for the reset request; -1 on timeout
  task automatic wait_evt(input bit sel, input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim; i++) begin
      @(posedge clock_in);
      #1;
      if ((sel ? system_reset_request_out : nmi_request_out) === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    for (int a = 0; a < 16; a++) begin
      rd_reg(a[3:0], rd);
      `CHK("reg after reset", 8'h00, rd)
    end
    `CHK("nmi flag after reset", 1'b0, timeout_nmi_flag_out)
    `CHK("reset request after reset", 1'b0, system_reset_request_out)
  endtask

  task automatic t_overflow;
    wr(`WWDT_ADDR_CTRL, 8'h04);
    wr(`WWDT_ADDR_RELOAD, 8'hFF);
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    t0 = cyc;
    rd_reg(`WWDT_ADDR_CNT_HI, rd);
    `CHK("count high after service", 8'hFF, rd)
    wait_evt(1'b0, 700, t1);
    `CHK("overflow delay", 512, t1 - t0)
    `CHK("nmi flag on overflow", 1'b1, timeout_nmi_flag_out)
    @(posedge clock_in);
    #1;
    `CHK("nmi pulse one cycle", 1'b0, nmi_request_out)
    rd_reg(`WWDT_ADDR_STATUS, rd);
    `CHK("status in prewarning", 8'h03, rd)
    // a late service must not rescue the system
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    wait_evt(1'b1, 200, t0);
    `CHK("prewarning length", 96, t0 - t1)
    rd_reg(`WWDT_ADDR_STATUS, rd);
    `CHK("status at reset request", 8'h05, rd)
    wr(`WWDT_ADDR_STATUS, 8'h01);
    `CHK("nmi flag cleared", 1'b0, timeout_nmi_flag_out)
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    repeat (50) @(posedge clock_in);
    #1;
    `CHK("reset request holds", 1'b1, system_reset_request_out)
  endtask

  task automatic t_window;
    wr(`WWDT_ADDR_CTRL, 8'h04);
    wr(`WWDT_ADDR_RELOAD, 8'h80);
    wr(`WWDT_ADDR_WINB, 8'h80);
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    @(posedge clock_in);
    debug_mode_in <= 1'b1;
    // frozen at exactly the boundary value, which is still allowed
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    wr(`WWDT_ADDR_CTRL, 8'h06);
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    rd_reg(`WWDT_ADDR_STATUS, rd);
    `CHK("service at boundary valid", 8'h00, rd)
    wr(`WWDT_ADDR_RELOAD, 8'h7F);
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    rd_reg(`WWDT_ADDR_STATUS, rd);
    `CHK("service above window valid", 8'h00, rd)
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    rd_reg(`WWDT_ADDR_STATUS, rd);
    `CHK("service in window invalid", 8'h02, rd)
    @(posedge clock_in);
    debug_mode_in <= 1'b0;
    wait_evt(1'b1, 200, t0);
    `CHK("reset after invalid service", 1'b1, system_reset_request_out)
    `CHK("no nmi on invalid service", 1'b0, timeout_nmi_flag_out)
  endtask

  task automatic t_debug_and_rates;
    wr(`WWDT_ADDR_CTRL, 8'h04);
    @(posedge clock_in);
    debug_mode_in <= 1'b1;
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    rd_reg(`WWDT_ADDR_CNT_LO, rd);
    `CHK("low byte cleared by service", 8'h00, rd)
    repeat (40) @(posedge clock_in);
    rd_reg(`WWDT_ADDR_CNT_LO, rd);
    `CHK("count held in debug", 8'h00, rd)
    @(posedge clock_in);
    debug_mode_in <= 1'b0;
    repeat (101) @(posedge clock_in);
    rd_reg(`WWDT_ADDR_CNT_LO, rd);
    `CHK("divide by 2 rate", 8'h33, rd)
    wr(`WWDT_ADDR_CTRL, 8'h05);
    wr(`WWDT_ADDR_SERVICE, 8'h00);
    repeat (400) @(posedge clock_in);
    rd_reg(`WWDT_ADDR_CNT_LO, rd);
    `CHK("divide by 128 rate", 8'h03, rd)
    rd_reg(`WWDT_ADDR_CNT_HI, rd);
    `CHK("count high from reload zero", 8'h00, rd)
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    t_overflow();
    do_reset();
    t_window();
    do_reset();
    t_debug_and_rates();
    close_out();
  end

  // the scenarios need about 1500 cycles; a generous margin covers a hang
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    close_out();
  end
endmodule
